// >>> hdl/pin_ctrl_pkg.sv
package pin_ctrl_pkg;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned CLK_MHZ = 100; // cycles per microsecond
	localparam int unsigned HOLD_US = 200; // least low time on a control input
	localparam int unsigned HOLD_CYC = HOLD_US * CLK_MHZ;
	localparam int unsigned HOLD_MARGIN_CYC = 16; // host holds a little longer than needed
	localparam int unsigned BLINK_MS = 100; // activity lamp half period
	localparam int unsigned BLINK_CYC = BLINK_MS * 1000 * CLK_MHZ;
	localparam int unsigned CNT_W = 24;
	// ----------------------------------------
	// serial frame encodings
	// ----------------------------------------
	localparam int unsigned DATA_W = 8;
	localparam int unsigned FIFO_DEPTH = 8;
	localparam logic [2:0] PAR_NONE = 3'h0;
	localparam logic [2:0] PAR_EVEN = 3'h1;
	localparam logic [2:0] PAR_ODD = 3'h2;
	localparam logic [2:0] PAR_SPACE = 3'h3;
	localparam logic [2:0] PAR_MARK = 3'h4;
	localparam logic [2:0] MIN_DATA_BITS = 3'h5; // data length code 0 means five bits
	localparam logic [1:0] STOP_1 = 2'h0;
	localparam logic [1:0] STOP_1_5 = 2'h1;
	localparam logic [1:0] STOP_2 = 2'h2;
	localparam logic [2:0] HALVES_PER_BIT = 3'h2;
	// ----------------------------------------
	// host controller registers
	// ----------------------------------------
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam logic [31:0] CTRL_RESET_VAL = 32'h00000000;
	localparam int unsigned CTRL_RESET_GO = 0;
	localparam int unsigned CTRL_RESTORE_GO = 1;
	localparam int unsigned CTRL_CONFIG_GO = 2;
	localparam int unsigned CTRL_CTS_HOLD = 3;
	localparam int unsigned CTRL_DSR_READY = 4;
	localparam int unsigned ST_REQ_DIR = 3;
	localparam int unsigned ST_DTR = 4;
	localparam int unsigned ST_ACT = 5;
	localparam int unsigned ST_LINK = 6;
	localparam int unsigned ST_TXD = 7;
endpackage

// >>> hdl/serial_pin_if.sv
`timescale 1ns/1ps
`default_nettype none
interface serial_pin_if;
	logic txd; // serial data, device to host
	logic request_or_direction_out; // request to send, or transceiver direction
	logic cts_n; // low lets the device send
	logic dtr_n; // device ready
	logic dsr_n; // attached equipment ready
	logic module_reset_n;
	logic factory_restore_n;
	logic config_select_n;
	logic eth_activity_led;
	logic link_led;
	modport dev (
		output txd, request_or_direction_out, dtr_n, eth_activity_led, link_led,
		input cts_n, dsr_n, module_reset_n, factory_restore_n, config_select_n
	);
	modport host (
		input txd, request_or_direction_out, dtr_n, eth_activity_led, link_led,
		output cts_n, dsr_n, module_reset_n, factory_restore_n, config_select_n
	);
endinterface
`default_nettype wire

// >>> hdl/sync_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module sync_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 8
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic flush,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_ff, rd_ptr_ff;
	logic [AW:0] count_ff;
	logic push, pop;

	// ----------------------------------------
	// handshakes
	// ----------------------------------------
	assign in_ready = (count_ff != AW'(0) + (AW+1)'(DEPTH)) && !flush;
	assign out_valid = (count_ff != '0) && !flush;
	assign out_data = mem[rd_ptr_ff];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// storage
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr_ff] <= in_data;
		end
	end

	// pointers and fill level, flush empties at once
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end else if (flush) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
			end
			count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

// >>> hdl/serial_module_pins.sv
// Operation
// - 200 us low on reset input resets
// - 200 us low on restore input restores defaults
// - 200 us low on config input enters command mode
// - full duplex: request line low permits sending
// - half duplex: device steers direction line itself
// - half duplex: direction low when nothing to send
// - full duplex: transmit only while clear-to-send low; code checks it only at frame start, a started frame runs to its stop bits
// - terminal ready output shows device ready
// - far side drives set-ready, device samples it
// - activity output reflects network transmission
// - link output reflects connection state
// - reserved pins left unconnected, no function
// - activity lamp blinks while sending, steady otherwise
// - link lamp lit while link is up
// - parity, five to eight bits, stop lengths
// - baud 300 to 115200, both sides alike; the 16-bit half_bit_div at 100 MHz reaches down to about 763 baud only
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module serial_module_pins #(
	parameter int unsigned hold_cyc = pin_ctrl_pkg::HOLD_CYC,
	parameter int unsigned blink_cyc = pin_ctrl_pkg::BLINK_CYC
) (
	input wire logic core_clk,
	input wire logic rst_b,
	serial_pin_if.dev pins,
	input wire logic [pin_ctrl_pkg::DATA_W-1:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic half_duplex_dir_enable,
	input wire logic [2:0] parity_mode,
	input wire logic [1:0] data_len,
	input wire logic [1:0] stop_len,
	input wire logic [15:0] half_bit_div,
	input wire logic eth_tx_active,
	input wire logic eth_link_up,
	output logic in_reset,
	output logic restore_pulse,
	output logic config_mode,
	output logic dsr_ready
);
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
	localparam int unsigned CW = pin_ctrl_pkg::CNT_W;

	logic [2:0] ctl_n;
	logic [2:0] qual_ff, fire_ff;
	logic [CW-1:0] hold_cnt_ff [3];
	logic [pin_ctrl_pkg::DATA_W-1:0] f_data, shift_ff;
	logic f_valid, f_pop, f_ready;
	tx_state_t state_ff;
	logic [15:0] div_ff;
	logic half_tick;
	logic [2:0] half_cnt_ff, bit_cnt_ff, halves_need, data_bits;
	logic [pin_ctrl_pkg::DATA_W-1:0] len_mask;
	logic par_bit_ff, nxt_par;
	logic txd_ff, dir_ff, dtr_n_ff, dsr_ff, cfg_ff;
	logic act_ff, link_ff, act_seen_ff;
	logic [CW-1:0] blink_cnt_ff;
	logic may_start;

	// ----------------------------------------
	// control input qualification
	// ----------------------------------------
	assign ctl_n = {pins.config_select_n, pins.factory_restore_n, pins.module_reset_n};

	// count consecutive low samples, a high sample restarts
	for (genvar g = 0; g < 3; g++) begin : g_qual
		always_ff @(posedge core_clk or negedge rst_b) begin
			if (!rst_b) begin
				hold_cnt_ff[g] <= '0;
				qual_ff[g] <= 1'b0;
				fire_ff[g] <= 1'b0;
			end else if (ctl_n[g]) begin
				hold_cnt_ff[g] <= '0;
				qual_ff[g] <= 1'b0;
				fire_ff[g] <= 1'b0;
			end else if (hold_cnt_ff[g] == CW'(hold_cyc - 1)) begin
				qual_ff[g] <= 1'b1;
				fire_ff[g] <= !qual_ff[g];
			end else begin
				hold_cnt_ff[g] <= hold_cnt_ff[g] + 1'b1;
				fire_ff[g] <= 1'b0;
			end
		end
	end

	assign in_reset = qual_ff[0];
	assign restore_pulse = fire_ff[1];
	assign config_mode = cfg_ff;

	// command mode entered on a qualified low, left on module reset
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_ff <= 1'b0;
		end else if (qual_ff[0]) begin
			cfg_ff <= 1'b0;
		end else if (fire_ff[2]) begin
			cfg_ff <= 1'b1;
		end
	end

	// ----------------------------------------
	// transmit buffer
	// ----------------------------------------
	sync_fifo #(
		.WIDTH(pin_ctrl_pkg::DATA_W),
		.DEPTH(pin_ctrl_pkg::FIFO_DEPTH)
	) u_tx_fifo (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.flush(qual_ff[0]),
		.in_data(tx_data),
		.in_valid(tx_valid),
		.in_ready(f_ready),
		.out_data(f_data),
		.out_valid(f_valid),
		.out_ready(f_pop)
	);
	assign tx_ready = f_ready;

	// ----------------------------------------
	// serial transmitter
	// ----------------------------------------
	assign data_bits = 3'(data_len) + pin_ctrl_pkg::MIN_DATA_BITS - 3'h1;
	assign len_mask = pin_ctrl_pkg::DATA_W'(8'hFF >> (3'h3 - {1'b0, data_len}));
	assign halves_need = (state_ff != TX_STOP) ? pin_ctrl_pkg::HALVES_PER_BIT :
		(stop_len == pin_ctrl_pkg::STOP_1) ? 3'h2 :
		(stop_len == pin_ctrl_pkg::STOP_1_5) ? 3'h3 : 3'h4;
	// half duplex waits for the direction line, full duplex for clear-to-send
	assign may_start = half_duplex_dir_enable ? dir_ff : !pins.cts_n;
	assign f_pop = (state_ff == TX_IDLE) && f_valid && may_start && !qual_ff[0];
	assign half_tick = (state_ff != TX_IDLE) && (div_ff == half_bit_div);

	// parity of the masked character
	always_comb begin
		case (parity_mode)
			pin_ctrl_pkg::PAR_EVEN: nxt_par = ^(f_data & len_mask);
			pin_ctrl_pkg::PAR_ODD: nxt_par = ~^(f_data & len_mask);
			pin_ctrl_pkg::PAR_MARK: nxt_par = 1'b1;
			default: nxt_par = 1'b0;
		endcase
	end

	// half-bit rate divider, runs only inside a frame
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			div_ff <= '0;
		end else if (state_ff == TX_IDLE || half_tick) begin
			div_ff <= '0;
		end else begin
			div_ff <= div_ff + 1'b1;
		end
	end

	// frame sequencer
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= TX_IDLE;
			txd_ff <= 1'b1;
			shift_ff <= '0;
			par_bit_ff <= 1'b0;
			half_cnt_ff <= '0;
			bit_cnt_ff <= '0;
		end else if (qual_ff[0]) begin
			state_ff <= TX_IDLE;
			txd_ff <= 1'b1;
		end else if (f_pop) begin
			state_ff <= TX_START;
			txd_ff <= 1'b0;
			shift_ff <= f_data;
			par_bit_ff <= nxt_par;
			half_cnt_ff <= '0;
			bit_cnt_ff <= '0;
		end else if (half_tick) begin
			if (half_cnt_ff != halves_need - 3'h1) begin
				half_cnt_ff <= half_cnt_ff + 1'b1;
			end else begin
				half_cnt_ff <= '0;
				case (state_ff)
					TX_START: begin
						state_ff <= TX_DATA;
						txd_ff <= shift_ff[0];
					end
					TX_DATA: begin
						shift_ff <= shift_ff >> 1;
						bit_cnt_ff <= bit_cnt_ff + 1'b1;
						if (bit_cnt_ff != data_bits) begin
							txd_ff <= shift_ff[1];
						end else if (parity_mode != pin_ctrl_pkg::PAR_NONE) begin
							state_ff <= TX_PAR;
							txd_ff <= par_bit_ff;
						end else begin
							state_ff <= TX_STOP;
							txd_ff <= 1'b1;
						end
					end
					TX_PAR: begin
						state_ff <= TX_STOP;
						txd_ff <= 1'b1;
					end
					TX_STOP: state_ff <= TX_IDLE;
					default: state_ff <= TX_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------
	// handshake and direction pins
	// ----------------------------------------
	// half duplex: high while data waits or a frame is out, else receive
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			dir_ff <= 1'b1;
			dtr_n_ff <= 1'b1;
			dsr_ff <= 1'b0;
		end else begin
			if (qual_ff[0]) begin
				dir_ff <= !half_duplex_dir_enable;
			end else if (half_duplex_dir_enable) begin
				dir_ff <= f_valid || (state_ff != TX_IDLE);
			end else begin
				dir_ff <= 1'b0;
			end
			dtr_n_ff <= qual_ff[0];
			dsr_ff <= !pins.dsr_n;
		end
	end

	// ----------------------------------------
	// network lamps
	// ----------------------------------------
	// activity lamp toggles each blink period while sending, else off
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			blink_cnt_ff <= '0;
			act_ff <= 1'b0;
			act_seen_ff <= 1'b0;
			link_ff <= 1'b0;
		end else begin
			link_ff <= eth_link_up;
			act_seen_ff <= eth_tx_active;
			if (!act_seen_ff) begin
				blink_cnt_ff <= '0;
				act_ff <= 1'b0;
			end else if (blink_cnt_ff == CW'(blink_cyc - 1)) begin
				blink_cnt_ff <= '0;
				act_ff <= !act_ff;
			end else begin
				blink_cnt_ff <= blink_cnt_ff + 1'b1;
			end
		end
	end

	assign pins.txd = txd_ff;
	assign pins.request_or_direction_out = dir_ff;
	assign pins.dtr_n = dtr_n_ff;
	assign pins.eth_activity_led = act_ff;
	assign pins.link_led = link_ff;
	assign dsr_ready = dsr_ff;
endmodule
`default_nettype wire

// >>> hdl/serial_host_pins.sv
`timescale 1ns/1ps
`default_nettype none
module serial_host_pins #(
	parameter int unsigned hold_cyc = pin_ctrl_pkg::HOLD_CYC
) (
	input wire logic core_clk,
	input wire logic rst_b,
	serial_pin_if.host pins,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	localparam int unsigned CW = pin_ctrl_pkg::CNT_W;
	localparam logic [CW-1:0] LOW_LAST = CW'(hold_cyc + pin_ctrl_pkg::HOLD_MARGIN_CYC - 1);

	logic [31:0] ctrl_ff, prdata_ff;
	logic pready_ff, pslverr_ff, wr_ctrl, hit;
	logic [2:0] low_ff;
	logic [CW-1:0] low_cnt_ff [3];
	logic [31:0] status;

	// ----------------------------------------
	// apb slave, one wait-free access phase
	// ----------------------------------------
	assign hit = (paddr == pin_ctrl_pkg::REG_CTRL) || (paddr == pin_ctrl_pkg::REG_STATUS);
	assign wr_ctrl = psel && penable && pready_ff && pwrite && (paddr == pin_ctrl_pkg::REG_CTRL);
	assign status = {24'h000000, !pins.txd == 1'b0, pins.link_led, pins.eth_activity_led,
		!pins.dtr_n, pins.request_or_direction_out, low_ff};

	// answer in the first access cycle; read data caught at setup
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h00000000;
		end else begin
			pready_ff <= psel && !penable;
			pslverr_ff <= psel && !penable && !hit;
			if (psel && !penable) begin
				prdata_ff <= (paddr == pin_ctrl_pkg::REG_CTRL) ? ctrl_ff :
					(paddr == pin_ctrl_pkg::REG_STATUS) ? status : 32'h00000000;
			end
		end
	end

	// control word; go bits are self-clearing
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_ff <= pin_ctrl_pkg::CTRL_RESET_VAL;
		end else if (wr_ctrl) begin
			ctrl_ff <= {pwdata[31:3], 3'h0};
		end
	end

	// ----------------------------------------
	// timed low pulses on the three controls
	// ----------------------------------------
	for (genvar g = 0; g < 3; g++) begin : g_pulse
		always_ff @(posedge core_clk or negedge rst_b) begin
			if (!rst_b) begin
				low_ff[g] <= 1'b0;
				low_cnt_ff[g] <= '0;
			end else if (!low_ff[g]) begin
				low_cnt_ff[g] <= '0;
				low_ff[g] <= wr_ctrl && pwdata[g];
			end else if (low_cnt_ff[g] == LOW_LAST) begin
				low_ff[g] <= 1'b0;
			end else begin
				low_cnt_ff[g] <= low_cnt_ff[g] + 1'b1;
			end
		end
	end

	assign pins.module_reset_n = !low_ff[pin_ctrl_pkg::CTRL_RESET_GO];
	assign pins.factory_restore_n = !low_ff[pin_ctrl_pkg::CTRL_RESTORE_GO];
	assign pins.config_select_n = !low_ff[pin_ctrl_pkg::CTRL_CONFIG_GO];
	assign pins.cts_n = ctrl_ff[pin_ctrl_pkg::CTRL_CTS_HOLD];
	assign pins.dsr_n = !ctrl_ff[pin_ctrl_pkg::CTRL_DSR_READY];
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
endmodule
`default_nettype wire

// >>> tb/serial_pins_chk.sv
`timescale 1ns/1ps
`default_nettype none
module serial_pins_chk #(
	parameter int unsigned hold_cyc = pin_ctrl_pkg::HOLD_CYC
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic txd,
	input wire logic request_or_direction_out,
	input wire logic cts_n,
	input wire logic dtr_n,
	input wire logic dsr_n,
	input wire logic module_reset_n,
	input wire logic factory_restore_n,
	input wire logic config_select_n,
	input wire logic eth_activity_led,
	input wire logic link_led,
	input wire logic half_duplex_dir_enable,
	input wire logic eth_tx_active,
	input wire logic eth_link_up,
	input wire logic in_reset,
	input wire logic restore_pulse,
	input wire logic config_mode,
	input wire logic dsr_ready
);
	logic [15:0] low_ff [3];
	logic [7:0] cts_ff;
	logic [2:0] pin_n;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	assign pin_n = {config_select_n, factory_restore_n, module_reset_n};
	// consecutive low samples per control pin, saturating past the hold time
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			low_ff <= '{default: 16'h0000};
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (pin_n[i]) begin
					low_ff[i] <= 16'h0000;
				end else if (low_ff[i] <= hold_cyc) begin
					low_ff[i] <= low_ff[i] + 16'h0001;
				end
			end
		end
	end
	// cycles that clear-to-send has been held off
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cts_ff <= 8'h00;
		end else if (!cts_n) begin
			cts_ff <= 8'h00;
		end else if (cts_ff != 8'hFF) begin
			cts_ff <= cts_ff + 8'h01;
		end
	end
	sequence act_on_s;
		eth_tx_active [*2];
	endsequence
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	reset_qual_a: assert property (in_reset == (low_ff[0] >= hold_cyc))
		else $error("reset qualification wrong");
	restore_once_a: assert property (restore_pulse == (low_ff[1] == hold_cyc))
		else $error("restore pulse wrong");
	config_entry_a: assert property ($rose(config_mode) |-> low_ff[2] == hold_cyc + 1)
		else $error("config mode entered early");
	rts_ready_a: assert property ((rst_b && !half_duplex_dir_enable && !in_reset) [*2] |->
		!request_or_direction_out) else $error("request line not low");
	dir_quiet_a: assert property (half_duplex_dir_enable && !request_or_direction_out |-> txd)
		else $error("sending while direction is receive");
	cts_block_a: assert property (cts_ff >= 8'h40 && !half_duplex_dir_enable |-> txd)
		else $error("sending while held off");
	dtr_ready_a: assert property ((rst_b && !in_reset) [*2] |-> !dtr_n)
		else $error("terminal ready missing");
	dsr_follow_a: assert property ($past(rst_b) |-> dsr_ready == !$past(dsr_n))
		else $error("set ready not sampled");
	act_blink_a: assert property (act_on_s |-> ##[1:12] ($changed(eth_activity_led) ||
		!eth_tx_active)) else $error("activity lamp not blinking");
	act_idle_a: assert property (!eth_tx_active [*3] |-> !eth_activity_led)
		else $error("activity lamp lit while idle");
	link_lamp_a: assert property ($past(rst_b) |-> link_led == $past(eth_link_up))
		else $error("link lamp wrong");
endmodule
`default_nettype wire

// >>> tb/tb_serial_module_pin_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_serial_module_pin_control;
	localparam int unsigned hold = 20;
	logic core_clk, rst_b, psel, penable, pwrite, pready, pslverr, tx_valid, tx_ready, half;
	logic eth_tx_active, eth_link_up, in_reset, restore_pulse, config_mode, dsr_ready;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [7:0] tx_data;
	logic [2:0] parity_mode;
	logic [1:0] data_len, stop_len;
	logic [15:0] half_bit_div;
	logic [32:0] q;
	int error_cnt, checks_done, cyc;
	serial_pin_if pins ();
	serial_module_pins #(.hold_cyc(hold), .blink_cyc(8)) u_serial_module_pins (
		.core_clk(core_clk), .rst_b(rst_b), .pins(pins.dev), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .half_duplex_dir_enable(half),
		.parity_mode(parity_mode), .data_len(data_len), .stop_len(stop_len),
		.half_bit_div(half_bit_div), .eth_tx_active(eth_tx_active), .eth_link_up(eth_link_up),
		.in_reset(in_reset), .restore_pulse(restore_pulse), .config_mode(config_mode),
		.dsr_ready(dsr_ready));
	serial_host_pins #(.hold_cyc(hold)) u_serial_host_pins (
		.core_clk(core_clk), .rst_b(rst_b), .pins(pins.host), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	serial_pins_chk #(.hold_cyc(hold)) u_serial_pins_chk (
		.core_clk(core_clk), .rst_b(rst_b), .txd(pins.txd), .cts_n(pins.cts_n),
		.request_or_direction_out(pins.request_or_direction_out), .dtr_n(pins.dtr_n),
		.dsr_n(pins.dsr_n), .module_reset_n(pins.module_reset_n), .link_led(pins.link_led),
		.factory_restore_n(pins.factory_restore_n), .config_select_n(pins.config_select_n),
		.eth_activity_led(pins.eth_activity_led), .half_duplex_dir_enable(half),
		.eth_tx_active(eth_tx_active), .eth_link_up(eth_link_up), .in_reset(in_reset),
		.restore_pulse(restore_pulse), .config_mode(config_mode), .dsr_ready(dsr_ready));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one apb transfer, result is {pslverr, prdata}
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		q = {pslverr, prdata};
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic push(input logic [7:0] d);
		tx_data <= d;
		tx_valid <= 1'b1;
		do @(posedge core_clk); while (tx_ready !== 1'b1);
		tx_valid <= 1'b0;
	endtask
	// capture one frame at four cycles a bit and compare with the expected bits
	task automatic frame(input logic [7:0] d);
		logic [7:0] m;
		logic [9:0] exp, got;
		logic p;
		int n, hp, k, ks;
		n = int'(data_len) + 5;
		hp = int'(parity_mode != pin_ctrl_pkg::PAR_NONE);
		m = d & (8'hFF >> (2'h3 - data_len));
		p = (parity_mode == pin_ctrl_pkg::PAR_EVEN) ? ^m : (parity_mode == pin_ctrl_pkg::PAR_ODD)
			? ~^m : (parity_mode == pin_ctrl_pkg::PAR_MARK);
		exp = 10'(m) | (10'(p) << n) | (10'h001 << (n + hp));
		got = 10'h000;
		do @(posedge core_clk); while (pins.txd !== 1'b0);
		repeat (2) @(posedge core_clk);
		for (int i = 0; i <= n + hp; i++) begin
			repeat (4) @(posedge core_clk);
			got[i] = pins.txd;
		end
		chk("frame", 33'(exp), 33'(got));
		chk("dir_busy", 33'(half), 33'(pins.request_or_direction_out));
		// half duplex: direction drops one cycle after the stop time ends
		ks = (stop_len == pin_ctrl_pkg::STOP_1) ? 3 :
			(stop_len == pin_ctrl_pkg::STOP_1_5) ? 5 : 7;
		k = 0;
		while (half && pins.request_or_direction_out === 1'b1 && k < 20) begin
			@(posedge core_clk);
			k++;
		end
		if (half) begin
			chk("stop_len", 33'(ks), 33'(k));
		end
		repeat (12) @(posedge core_clk);
		chk("dir_idle", 33'h0, 33'(pins.request_or_direction_out));
	endtask
	// start one control pulse and collect what the device reports
	task automatic ctl(input int b, input logic [2:0] exp);
		logic [2:0] seen;
		int pulses;
		seen = 3'b000;
		pulses = 0;
		apb(1'b1, pin_ctrl_pkg::REG_CTRL, 32'h1 << b);
		repeat (hold + 40) begin
			@(posedge core_clk);
			seen = seen | {config_mode, restore_pulse, in_reset};
			pulses += int'(restore_pulse);
		end
		chk("ctl_seen", 33'(exp), 33'(seen));
		chk("restores", 33'(b == 1), 33'(pulses));
	endtask
	// host register map: status after reset, unmapped access, control storage
	task automatic regs_test();
		apb(1'b0, pin_ctrl_pkg::REG_STATUS, 32'h0);
		chk("status", 33'h000000090, q);
		apb(1'b0, 12'h008, 32'h0);
		chk("unmapped", 33'h100000000, q);
		apb(1'b1, pin_ctrl_pkg::REG_CTRL, 32'hABCD0000);
		apb(1'b0, pin_ctrl_pkg::REG_CTRL, 32'h0);
		chk("ctrl", 33'h0ABCD0000, q);
	endtask
	// one frame in each parity, length and stop setting, both duplex modes
	task automatic frames_test();
		for (int i = 0; i < 5; i++) begin
			parity_mode <= 3'(i);
			data_len <= 2'(i);
			stop_len <= 2'(i);
			half <= i[0];
			@(posedge core_clk);
			push(8'hA5 ^ 8'(i * 37));
			frame(8'hA5 ^ 8'(i * 37));
		end
	endtask
	// clear-to-send held off keeps the frame back, set-ready reaches the device
	task automatic cts_test();
		apb(1'b1, pin_ctrl_pkg::REG_CTRL, 32'h18);
		push(8'h3C);
		repeat (70) @(posedge core_clk);
		chk("held_txd", 33'h1, 33'(pins.txd));
		chk("dsr", 33'h1, 33'(dsr_ready));
		apb(1'b1, pin_ctrl_pkg::REG_CTRL, 32'h0);
		frame(8'h3C);
	endtask
	// activity lamp blinks while sending, lamps read back once idle
	task automatic lamps_test();
		eth_link_up <= 1'b1;
		eth_tx_active <= 1'b1;
		q = 33'h0;
		repeat (40) begin
			@(posedge core_clk);
			q[0] = q[0] | (pins.eth_activity_led === 1'b1);
			q[1] = q[1] | (q[0] && pins.eth_activity_led === 1'b0);
		end
		chk("blink", 33'h3, q);
		eth_tx_active <= 1'b0;
		repeat (3) @(posedge core_clk);
		apb(1'b0, pin_ctrl_pkg::REG_STATUS, 32'h0);
		chk("lamps", 33'h0000000D0, q);
	endtask
	// timed low pulses on the three control inputs
	task automatic controls_test();
		ctl(1, 3'b010);
		ctl(2, 3'b100);
		ctl(0, 3'b101);
		chk("cfg_cleared", 33'h0, 33'({config_mode, in_reset}));
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// ----------------------------------------
	// clock, timeout and main sequence
	// ----------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			error_cnt++;
			conclude();
		end
	end
	initial begin
		{rst_b, psel, penable, pwrite, tx_valid, half, eth_tx_active, eth_link_up} = 8'h00;
		{paddr, pwdata, tx_data, parity_mode, data_len, stop_len} = 59'h0;
		half_bit_div = 16'h0001;
		{error_cnt, checks_done} = 0;
		repeat (3) @(posedge core_clk);
		rst_b <= 1'b1;
		// let the ready and direction lines leave their reset levels first
		repeat (2) @(posedge core_clk);
		regs_test();
		frames_test();
		cts_test();
		lamps_test();
		controls_test();
		conclude();
	end
endmodule
`default_nettype wire
